// ---- ccp_pkg.sv ----
package ccp_pkg;
  // Clock and times
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS    = CLK_HZ / 1_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned ALERT_US      = 256;
  localparam int unsigned WAKE_LOW_MS   = 100;
  localparam int unsigned RESET_HOLD_MS = 10_000;
  localparam int unsigned SW_OFF_MS     = 3_000;
  localparam int unsigned BLINK_CYC     = BLINK_HALF_MS * CLK_PER_MS;
  localparam int unsigned ALERT_CYC     = ALERT_US * CLK_PER_US;
  localparam int unsigned WAKE_CYC      = WAKE_LOW_MS * CLK_PER_MS;
  localparam int unsigned RESET_CYC     = RESET_HOLD_MS * CLK_PER_MS;
  localparam int unsigned SW_OFF_CYC    = SW_OFF_MS * CLK_PER_MS;
  // Register offsets
  localparam logic [7:0] ADR_LIMIT  = 8'h00;
  localparam logic [7:0] ADR_CTRL   = 8'h04;
  localparam logic [7:0] ADR_THERM  = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  // Field positions
  localparam int LIM_EN_BIT   = 6;
  localparam int CTRL_DIS_BIT = 0;
  localparam int CTRL_CHG_BIT = 4;
  localparam int CTRL_BST_BIT = 5;
  localparam int CTRL_SHIP_BIT = 7;
  // Reset values
  localparam logic [6:0] LIMIT_RST = 7'h7F;
  localparam logic [7:0] CTRL_RST  = 8'h30;
  localparam logic [7:0] THERM_RST = 8'h78;
  // Pin and comparator inputs
  typedef struct packed {
    logic batt_low;
    logic batt_at_cv;
    logic term_low;
    logic recharge;
    logic limit_hit;
    logic overload;
    logic ntc_ok;
    logic fault;
    logic detect_busy;
    logic high_voltage_charger_port;
    logic supply;
    logic boost_pin;
    logic charge_n;
    logic wake_n;
  } ccp_sense_type;
  localparam int SENSE_W = $bits(ccp_sense_type);
  typedef enum logic [2:0] {PH_IDLE, PH_PRE, PH_FAST, PH_CV, PH_DONE} ccp_phase_type;
  typedef enum logic [1:0] {SW_ON, SW_SHIP, SW_RST_OFF} ccp_switch_type;
endpackage

// ---- ccp_charger_ctrl.sv ----
`timescale 1ns/1ps
// Function
// - Indicator low while charging, else released
// - Any fault blinks indicator at 1 Hz
// - Indicator disable bit releases indicator output
// - Status change or fault: 256 us alert
// - Boost needs control bit and pin high
// - Charging needs control bit and pin low
// - Applied limit is lower of two
// - Limit enable clear uses register only
// - Long wake low exits shipping mode
// - No supply, 10 s low: 3 s off
// - Mux select low during detection
// - After detection low only for charger port
// - Precharge, constant current, constant voltage phases
// - Low current in constant voltage terminates
// - Below recharge threshold restarts charging
// - Limit hit: cut charge, then supplement if also overloaded
// - Hot die reduces charge current
// - Thermistor out of range suspends power
module ccp_charger_ctrl
  import ccp_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_CYC,
  parameter int unsigned ALERT_CYCLES = ALERT_CYC,
  parameter int unsigned WAKE_CYCLES  = WAKE_CYC,
  parameter int unsigned RESET_CYCLES = RESET_CYC,
  parameter int unsigned OFF_CYCLES   = SW_OFF_CYC
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [7:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Pins and sensed levels
  input  wire ccp_sense_type sense_i,
  input  wire logic [7:0]    die_temp_i,
  input  wire logic [5:0]    res_limit_i,
  // Open-drain pins
  output logic               stat_o,
  output logic               stat_oe_o,
  output logic               alert_o,
  output logic               alert_oe_o,
  output logic               mux_sel_o,
  output logic               mux_sel_oe_o,
  // Power stage controls
  output logic               charge_en_o,
  output logic               boost_en_o,
  output logic               switch_on_o,
  output logic               charge_cut_o,
  output logic               supplement_o,
  output logic               thermal_reduce_o,
  output logic [5:0]         applied_limit_o
);

  localparam int RAW_W = SENSE_W + 14;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [RAW_W-1:0] raw_in;
  logic [RAW_W-1:0] meta_reg;
  logic [RAW_W-1:0] sync_reg;
  ccp_sense_type    s;
  logic [7:0]       temp_s;
  logic [5:0]       res_s;

  assign raw_in = {die_temp_i, res_limit_i, sense_i};

  genvar gi;
  generate
    for (gi = 0; gi < RAW_W; gi++) begin : g_sync
      // No reset: active-low pins keep their idle level
      // Avoids false wake and charge edges after reset
      always_ff @(posedge clk_i) begin
        meta_reg[gi] <= raw_in[gi];
        sync_reg[gi] <= meta_reg[gi];
      end
    end
  endgenerate

  assign s      = ccp_sense_type'(sync_reg[SENSE_W-1:0]);
  assign res_s  = sync_reg[SENSE_W+5:SENSE_W];
  assign temp_s = sync_reg[RAW_W-1:SENSE_W+6];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [6:0]     limit_reg;
  logic [7:0]     ctrl_reg;
  logic [7:0]     therm_reg;
  logic [31:0]    dat_reg;
  logic           ack_reg;
  logic           ship_req;
  logic           wr_go;
  logic           rd_go;
  logic [31:0]    status_word;
  ccp_phase_type  phase_reg;
  ccp_switch_type sw_reg;
  logic           high_voltage_charger_port_reg;
  logic           charging;

  assign wr_go    = cyc_i && stb_i && we_i && !ack_reg && sel_i[0];
  assign rd_go    = cyc_i && stb_i && !we_i && !ack_reg;
  assign ship_req = wr_go && (adr_i == ADR_CTRL) && dat_i[CTRL_SHIP_BIT];
  assign status_word = {17'h0_0000, s.fault, applied_limit_o, high_voltage_charger_port_reg, (sw_reg == SW_SHIP),
                        switch_on_o, boost_en_o, charging, phase_reg};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_reg <= LIMIT_RST;
      ctrl_reg  <= CTRL_RST;
      therm_reg <= THERM_RST;
    end else if (wr_go) begin
      if (adr_i == ADR_LIMIT) begin
        limit_reg <= dat_i[6:0];
      end else if (adr_i == ADR_CTRL) begin
        ctrl_reg <= {1'b0, dat_i[6:0]};
      end else if (adr_i == ADR_THERM) begin
        therm_reg <= dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      if (adr_i == ADR_LIMIT) begin
        dat_reg <= {25'h000_0000, limit_reg};
      end else if (adr_i == ADR_CTRL) begin
        dat_reg <= {24'h00_0000, ctrl_reg};
      end else if (adr_i == ADR_THERM) begin
        dat_reg <= {24'h00_0000, therm_reg};
      end else if (adr_i == ADR_STATUS) begin
        dat_reg <= status_word;
      end else begin
        dat_reg <= 32'h0000_0000;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Charge phase sequencer
  logic chg_ok;

  assign chg_ok   = ctrl_reg[CTRL_CHG_BIT] && !s.charge_n;
  assign charging = (phase_reg == PH_PRE) || (phase_reg == PH_FAST) || (phase_reg == PH_CV);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PH_IDLE;
    end else if (!chg_ok) begin
      phase_reg <= PH_IDLE;
    end else begin
      case (phase_reg)
        PH_IDLE: phase_reg <= s.batt_low ? PH_PRE : PH_FAST;
        PH_PRE: begin
          if (!s.batt_low) begin
            phase_reg <= PH_FAST;
          end
        end
        PH_FAST: begin
          if (s.batt_low) begin
            phase_reg <= PH_PRE;
          end else if (s.batt_at_cv) begin
            phase_reg <= PH_CV;
          end
        end
        PH_CV: begin
          if (s.term_low) begin
            phase_reg <= PH_DONE;
          end
        end
        PH_DONE: begin
          if (s.recharge) begin
            phase_reg <= s.batt_low ? PH_PRE : PH_FAST;
          end
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage gating
  logic chg_en_reg;
  logic bst_en_reg;
  logic cut_reg;
  logic supp_reg;
  logic hot_reg;
  logic [5:0] lim_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_en_reg <= 1'b0;
      bst_en_reg <= 1'b0;
    end else begin
      chg_en_reg <= chg_ok && charging && s.ntc_ok;
      bst_en_reg <= ctrl_reg[CTRL_BST_BIT] && s.boost_pin && s.ntc_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cut_reg  <= 1'b0;
      supp_reg <= 1'b0;
    end else begin
      cut_reg  <= s.limit_hit;
      supp_reg <= s.limit_hit && s.overload && cut_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hot_reg <= 1'b0;
    end else begin
      hot_reg <= temp_s > therm_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_reg <= LIMIT_RST[5:0];
    end else begin
      lim_reg <= (limit_reg[LIM_EN_BIT] && (res_s < limit_reg[5:0])) ? res_s : limit_reg[5:0];
    end
  end

  assign charge_en_o      = chg_en_reg;
  assign boost_en_o       = bst_en_reg;
  assign charge_cut_o     = cut_reg;
  assign supplement_o     = supp_reg;
  assign thermal_reduce_o = hot_reg;
  assign applied_limit_o  = lim_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Indicator and alert
  logic [31:0] blink_cnt;
  logic        blink_reg;
  logic        stat_oe_reg;
  logic [31:0] alert_cnt;
  logic        alert_oe_reg;
  logic [1:0]  code;
  logic [1:0]  code_prev_reg;
  logic        fault_prev_reg;
  logic        event_hit;

  assign code = (phase_reg == PH_DONE) ? 2'h3 : (phase_reg == PH_PRE) ? 2'h1 : charging ? 2'h2 : 2'h0;
  assign event_hit = (code != code_prev_reg) || (s.fault && !fault_prev_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i || !s.fault) begin
      blink_cnt <= 32'h0000_0000;
      blink_reg <= 1'b1;
    end else if (blink_cnt == BLINK_CYCLES - 1) begin
      blink_cnt <= 32'h0000_0000;
      blink_reg <= !blink_reg;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_oe_reg <= 1'b0;
    end else begin
      stat_oe_reg <= !ctrl_reg[CTRL_DIS_BIT] && (s.fault ? blink_reg : charging);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_prev_reg  <= 2'h0;
      fault_prev_reg <= 1'b0;
    end else begin
      code_prev_reg  <= code;
      fault_prev_reg <= s.fault;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_cnt    <= 32'h0000_0000;
      alert_oe_reg <= 1'b0;
    end else if (alert_cnt != 0) begin
      alert_cnt <= alert_cnt - 32'h0000_0001;
      if (alert_cnt == 1) begin
        alert_oe_reg <= 1'b0;
      end
    end else if (event_hit) begin
      alert_cnt    <= ALERT_CYCLES;
      alert_oe_reg <= 1'b1;
    end
  end

  assign stat_o     = 1'b0;
  assign stat_oe_o  = stat_oe_reg;
  assign alert_o    = 1'b0;
  assign alert_oe_o = alert_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mux select during detection
  logic busy_prev_reg;
  logic high_voltage_charger_port_next;
  logic mux_oe_reg;

  always_comb begin
    high_voltage_charger_port_next = high_voltage_charger_port_reg;
    if (!s.supply || s.detect_busy) begin
      high_voltage_charger_port_next = 1'b0;
    end else if (busy_prev_reg) begin
      high_voltage_charger_port_next = s.high_voltage_charger_port;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_prev_reg <= 1'b0;
      high_voltage_charger_port_reg     <= 1'b0;
      mux_oe_reg    <= 1'b0;
    end else begin
      busy_prev_reg <= s.detect_busy;
      high_voltage_charger_port_reg     <= high_voltage_charger_port_next;
      mux_oe_reg    <= s.detect_busy || high_voltage_charger_port_next;
    end
  end

  assign mux_sel_o    = 1'b0;
  assign mux_sel_oe_o = mux_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Battery switch, shipping mode and system reset
  logic [31:0] low_cnt;
  logic [31:0] off_cnt;
  logic        wake_prev_reg;
  logic        sw_on_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_reg        <= SW_ON;
      low_cnt       <= 32'h0000_0000;
      off_cnt       <= 32'h0000_0000;
      wake_prev_reg <= 1'b1;
    end else begin
      wake_prev_reg <= s.wake_n;
      case (sw_reg)
        SW_ON: begin
          if (ship_req) begin
            sw_reg  <= SW_SHIP;
            low_cnt <= 32'h0000_0000;
          end else if (!s.supply && !s.wake_n) begin
            low_cnt <= low_cnt + 32'h0000_0001;
            if (low_cnt == RESET_CYCLES - 1) begin
              sw_reg  <= SW_RST_OFF;
              off_cnt <= 32'h0000_0000;
            end
          end else begin
            low_cnt <= 32'h0000_0000;
          end
        end
        SW_SHIP: begin
          if (s.wake_n) begin
            low_cnt <= 32'h0000_0000;
          end else if (wake_prev_reg) begin
            low_cnt <= 32'h0000_0001;
          end else if (low_cnt == WAKE_CYCLES) begin
            sw_reg  <= SW_ON;
            low_cnt <= 32'h0000_0000;
          end else if (low_cnt != 0) begin
            low_cnt <= low_cnt + 32'h0000_0001;
          end
        end
        SW_RST_OFF: begin
          off_cnt <= off_cnt + 32'h0000_0001;
          low_cnt <= 32'h0000_0000;
          if (off_cnt == OFF_CYCLES - 1) begin
            sw_reg <= SW_ON;
          end
        end
        default: sw_reg <= SW_ON;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_on_reg <= 1'b1;
    end else begin
      sw_on_reg <= (sw_reg == SW_ON);
    end
  end

  assign switch_on_o = sw_on_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_stat_charging: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_reg[CTRL_DIS_BIT] && !s.fault && charging) |=> stat_oe_o)
    else $error("indicator not driven while charging");
  a_stat_blink: assert property (@(posedge clk_i) disable iff (rst_i)
    (s.fault && blink_cnt != BLINK_CYCLES - 1) |=> $stable(blink_reg))
    else $error("blink toggled early");
  a_stat_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[CTRL_DIS_BIT] |=> !stat_oe_o)
    else $error("indicator driven while disabled");
  a_alert_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alert_oe_o) |-> alert_oe_o [*8])
    else $error("alert pulse too short");
  a_alert_norestart: assert property (@(posedge clk_i) disable iff (rst_i)
    (alert_cnt > 1) |=> (alert_cnt == $past(alert_cnt) - 1) && alert_oe_o)
    else $error("alert pulse retriggered");
  a_boost_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    boost_en_o |-> $past(ctrl_reg[CTRL_BST_BIT]) && $past(s.boost_pin))
    else $error("boost enabled without both enables");
  a_charge_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    charge_en_o |-> $past(ctrl_reg[CTRL_CHG_BIT]) && !$past(s.charge_n))
    else $error("charging without both enables");
  a_limit_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 applied_limit_o <= $past(limit_reg[5:0]))
    else $error("applied limit above register field");
  a_limit_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    !limit_reg[LIM_EN_BIT] |=> applied_limit_o == $past(limit_reg[5:0]))
    else $error("resistor limit used while disabled");
  a_ship_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    (sw_reg == SW_SHIP && !s.wake_n && !wake_prev_reg && low_cnt == WAKE_CYCLES) |=> ##1 switch_on_o)
    else $error("no exit from shipping mode");
  a_reset_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (sw_reg == SW_RST_OFF) |=> !switch_on_o)
    else $error("switch on during reset off time");
  a_mux_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    s.detect_busy |=> mux_sel_oe_o)
    else $error("mux select released during detection");
  a_mux_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s.detect_busy && !high_voltage_charger_port_next) |=> !mux_sel_oe_o)
    else $error("mux select held without charger port");
  a_phase_pre: assert property (@(posedge clk_i) disable iff (rst_i)
    (chg_ok && phase_reg == PH_IDLE && s.batt_low) |=> phase_reg == PH_PRE)
    else $error("precharge not chosen for low battery");
  a_cv_term: assert property (@(posedge clk_i) disable iff (rst_i)
    (chg_ok && phase_reg == PH_CV && s.term_low) |=> phase_reg == PH_DONE ##1 (!stat_oe_o || $past(s.fault)))
    else $error("no termination in constant voltage");
  a_recharge: assert property (@(posedge clk_i) disable iff (rst_i)
    (chg_ok && phase_reg == PH_DONE && s.recharge) |=> charging)
    else $error("no recharge below threshold");
  a_supply_order: assert property (@(posedge clk_i) disable iff (rst_i)
    supplement_o |-> $past(charge_cut_o) && charge_cut_o)
    else $error("supplement before charge cut");
  a_thermal: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 thermal_reduce_o == ($past(temp_s) > $past(therm_reg)))
    else $error("thermal reduction mismatch");
  a_ntc_suspend: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.ntc_ok |=> !charge_en_o && !boost_en_o)
    else $error("power stage on with thermistor out of range");

endmodule // ccp_charger_ctrl

// ---- ccp_host_model.sv ----
`timescale 1ns/1ps
module ccp_host_model (
  // Open-drain enables from the block
  input  wire logic stat_oe_i,
  input  wire logic alert_oe_i,
  input  wire logic mux_sel_oe_i,
  // Levels seen by the host
  output logic      stat_pin_o,
  output logic      alert_pin_o,
  output logic      mux_pin_o
);
  assign stat_pin_o  = !stat_oe_i;
  assign alert_pin_o = !alert_oe_i;
  assign mux_pin_o   = !mux_sel_oe_i;
endmodule // ccp_host_model

// ---- charger_control_pin_logic_test.sv ----
`timescale 1ns/1ps
module charger_control_pin_logic_test;
  import ccp_pkg::*;
  logic          clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, en;
  logic [7:0]    adr_i, die_temp_i;
  logic [3:0]    sel_i;
  logic [31:0]   dat_i, dat_o, q;
  ccp_sense_type s;
  logic [5:0]    res_limit_i, applied_limit_o, lim;
  logic          stat_o, stat_oe_o, alert_o, alert_oe_o, mux_sel_o, mux_sel_oe_o;
  logic          charge_en_o, boost_en_o, switch_on_o, charge_cut_o, supplement_o, thermal_reduce_o;
  logic          stat_pin, alert_pin, mux_pin;
  int            mismatches, comparisons, n, w;
  logic [7:0]    radr [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [7:0]    rexp [4] = '{8'h7F, 8'h30, 8'h78, 8'h00};
  logic [7:0]    ph [5]   = '{8'h81, 8'h02, 8'h43, 8'h64, 8'h12};

  ccp_charger_ctrl #(.BLINK_CYCLES(20), .ALERT_CYCLES(10), .WAKE_CYCLES(10), .RESET_CYCLES(40), .OFF_CYCLES(20))
    u_ccp_charger_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sense_i(s), .die_temp_i(die_temp_i),
    .res_limit_i(res_limit_i), .stat_o(stat_o), .stat_oe_o(stat_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
    .mux_sel_o(mux_sel_o), .mux_sel_oe_o(mux_sel_oe_o), .charge_en_o(charge_en_o), .boost_en_o(boost_en_o),
    .switch_on_o(switch_on_o), .charge_cut_o(charge_cut_o), .supplement_o(supplement_o),
    .thermal_reduce_o(thermal_reduce_o), .applied_limit_o(applied_limit_o));
  ccp_host_model u_ccp_host_model (.stat_oe_i(stat_oe_o), .alert_oe_i(alert_oe_o), .mux_sel_oe_i(mux_sel_oe_o),
    .stat_pin_o(stat_pin), .alert_pin_o(alert_pin), .mux_pin_o(mux_pin));

  ////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int k;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w_en, a, d, 4'hF};
    k = 0;
    do begin
      tick(1);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      test_done();
    end
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    tick(1);
  endtask

  task automatic bound(input int used, input int lim);
    if (used >= lim) begin
      mismatches++;
      test_done();
    end
  endtask

  function automatic logic [5:0] exp_limit(input logic e, input logic [5:0] f, input logic [5:0] r);
    return (e && r < f) ? r : f;
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    tick(20000);
    mismatches++;
    test_done();
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
    s = '{wake_n: 1'b1, charge_n: 1'b1, supply: 1'b1, ntc_ok: 1'b1, default: 1'b0};
    {die_temp_i, res_limit_i} = {8'h00, 6'h3F};
    void'($urandom(32'h2ba8));
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    foreach (radr[i]) begin
      wb(1'b0, radr[i], 32'h0000_0000);
      check("reg", q, {24'h0, rexp[i]});
    end
    repeat (12) begin
      lim = 6'($urandom);
      en = 1'($urandom);
      res_limit_i <= 6'($urandom);
      wb(1'b1, ADR_LIMIT, {25'h0, en, lim});
      tick(4);
      check("limit", applied_limit_o, exp_limit(en, lim, res_limit_i));
    end
    s.batt_low <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      {s.boost_pin, s.charge_n} <= 2'(k);
      wb(1'b1, ADR_CTRL, {26'h0, 2'(k >> 2), 4'h0});
      tick(4);
      check("charge", charge_en_o, k[2] & !k[0]);
      check("boost", boost_en_o, k[3] & k[1]);
      check("stat", stat_pin, !(k[2] & !k[0]));
    end
    {s.ntc_ok, s.charge_n} <= 2'b00;
    tick(5);
    check("ntc", {charge_en_o, boost_en_o}, 2'b00);
    s.ntc_ok <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h0000_0031);
    tick(4);
    check("indicator_disable_bit", stat_pin, 1'b1);
    check("od_data", {stat_o, alert_o, mux_sel_o}, 3'b000);
    wb(1'b1, ADR_CTRL, 32'h0000_0030);
    foreach (ph[i]) begin
      {s.batt_low, s.batt_at_cv, s.term_low, s.recharge} <= ph[i][7:4];
      tick(5);
      wb(1'b0, ADR_STATUS, 32'h0000_0000);
      check("phase", q[2:0], ph[i][2:0]);
    end
    {s.recharge, s.limit_hit} <= 2'b01;
    tick(5);
    check("cut", {charge_cut_o, supplement_o}, 2'b10);
    s.overload <= 1'b1;
    tick(5);
    check("supp", {charge_cut_o, supplement_o}, 2'b11);
    {s.limit_hit, s.overload, die_temp_i} <= {2'b00, 8'h79};
    tick(5);
    check("hot", thermal_reduce_o, 1'b1);
    {die_temp_i, s.detect_busy} <= {8'h78, 1'b1};
    tick(5);
    check("hot_off", thermal_reduce_o, 1'b0);
    check("mux_busy", mux_pin, 1'b0);
    {s.high_voltage_charger_port, s.detect_busy} <= 2'b10;
    tick(5);
    check("mux_hv", mux_pin, 1'b0);
    {s.high_voltage_charger_port, s.detect_busy} <= 2'b01;
    tick(3);
    s.detect_busy <= 1'b0;
    tick(5);
    check("mux_other", mux_pin, 1'b1);
    s.fault <= 1'b1;
    for (n = 0; n < 50 && alert_pin !== 1'b0; n++)
      tick(1);
    bound(n, 50);
    s.batt_low <= 1'b1;
    for (w = 0; w < 50 && alert_pin === 1'b0; w++)
      tick(1);
    bound(w, 50);
    check("alert", w, 10);
    tick(20);
    check("no_retrig", alert_pin, 1'b1);
    w = 0;
    for (n = 0; n < 80; n++) begin
      en = stat_pin;
      tick(1);
      w += int'(stat_pin !== en);
    end
    check("blink", w, 4);
    s.fault <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'h0000_00B0);
    tick(4);
    s.wake_n <= 1'b0;
    tick(5);
    s.wake_n <= 1'b1;
    tick(20);
    check("ship", switch_on_o, 1'b0);
    s.wake_n <= 1'b0;
    tick(20);
    s.wake_n <= 1'b1;
    tick(4);
    check("wake", switch_on_o, 1'b1);
    {s.supply, s.wake_n} <= 2'b00;
    for (n = 0; n < 80 && switch_on_o !== 1'b0; n++)
      tick(1);
    bound(n, 80);
    s.wake_n <= 1'b1;
    for (w = 0; w < 60 && switch_on_o !== 1'b1; w++)
      tick(1);
    bound(w, 60);
    check("rst_off", w >= 20 && n > 40, 1'b1);
    check("rst_on", switch_on_o, 1'b1);
    test_done();
  end
endmodule // charger_control_pin_logic_test
